// file: fsp_core_model.sv
// Processor core model: AXI4-Lite register master and program byte fetch.
// Assumes calls from one process, each entered just after a rising edge.
`timescale 1ns/10ps
module fsp_core_model (
  input  wire fsp_pkg::fsp_axi_rsp_t i_axi,
  input  wire logic                  i_clk,
  input  wire logic [7:0]            i_prog_rd_data,
  output fsp_pkg::fsp_axi_req_t      o_axi,
  output logic                       o_prog_rd_req,
  output logic [15:0]                o_prog_rd_addr
);
  import fsp_pkg::*;
  initial begin
    o_axi = '0;
    o_prog_rd_req = 1'b0;
    o_prog_rd_addr = 16'h0000;
  end
  // Released address and data lines show the inverse, never the old value
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic ok);
    ok = 1'b0;
    o_axi.awvalid <= 1'b1;
    o_axi.awaddr <= a;
    o_axi.wvalid <= 1'b1;
    o_axi.wdata <= d;
    o_axi.wstrb <= 4'hf;
    o_axi.bready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge i_clk);
      if (o_axi.awvalid && i_axi.awready) begin
        o_axi.awvalid <= 1'b0;
        o_axi.awaddr <= ~a;
      end
      if (o_axi.wvalid && i_axi.wready) begin
        o_axi.wvalid <= 1'b0;
        o_axi.wdata <= ~d;
      end
      if (i_axi.bvalid === 1'b1) ok = 1'b1;
    end
    // Bready stays high: lowering it here would clash with the next call
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r,
                    output logic ok);
    ok = 1'b0;
    o_axi.arvalid <= 1'b1;
    o_axi.araddr <= a;
    o_axi.rready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge i_clk);
      if (o_axi.arvalid && i_axi.arready) begin
        o_axi.arvalid <= 1'b0;
        o_axi.araddr <= ~a;
      end
      if (i_axi.rvalid === 1'b1) begin
        d = i_axi.rdata;
        r = i_axi.rresp;
        ok = 1'b1;
      end
    end
    // Rready stays high for the same reason
  endtask
  // Byte answer lands in the cycle after the request edge
  task automatic fetch(input logic [15:0] a, output logic [7:0] d);
    o_prog_rd_req <= 1'b1;
    o_prog_rd_addr <= a;
    @(posedge i_clk);
    o_prog_rd_req <= 1'b0;
    o_prog_rd_addr <= ~a;
    @(posedge i_clk);
    d = i_prog_rd_data;
  endtask
endmodule

// file: fsp_pkg.sv
// Constants and carrier types for the flash self-program sequencer.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
package fsp_pkg;
  // Register byte offsets
  localparam logic [31:0] OFS_CTRL  = 32'h0000_0000;
  localparam logic [31:0] OFS_Z     = 32'h0000_0004;
  localparam logic [31:0] OFS_DATA  = 32'h0000_0008;
  localparam logic [31:0] OFS_STORE = 32'h0000_000c;
  localparam logic [31:0] OFS_INFO  = 32'h0000_0010;
  // Control/status bit positions
  localparam int BIT_EN    = 0;
  localparam int BIT_BUSY  = 6;
  localparam int BIT_IEN   = 7;
  // Command codes on the low five control bits
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;
  // Flash geometry, Z pointer fields
  localparam int         PAGE_WORDS   = 32;
  localparam int         FLASH_WORDS  = 4096;
  localparam int         Z_WORD_LSB   = 1;
  localparam int         Z_PAGE_LSB   = 6;
  localparam logic [6:0] NO_READ_WHILE_WRITE_SECTION_PAGE    = 7'h60;
  localparam logic [15:0] APP_RESET   = 16'h0000;
  localparam logic [15:0] BOOT_RESET  = 16'h0f00;
  localparam logic [5:0] LOCK_RESET   = 6'h3f;
  localparam logic [2:0] ARM_WINDOW   = 3'h4;
  // Programming time
  localparam int CLK_PERIOD_NS  = 5;
  localparam int OP_TIME_MIN_NS = 3700000;
  localparam int OP_TIME_MAX_NS = 4500000;
  localparam int OP_CYCLES_MIN  = (OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_CYCLES_MAX  = OP_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_LOCK} fsp_op_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } fsp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fsp_axi_rsp_t;
endpackage

// file: fsp_sequencer.sv
// Flash self-program sequencer: page buffer, erase, write, lock bits.
// Assumes an AXI4-Lite master on i_clk and a same-clock EEPROM status.
// How it works
// - Fuse high selects address zero, else boot
// - No register path can alter fuses
// - Z pointer gives word and page fields
// - Page address latched when operation starts
// - Lock command ignores Z pointer completely
// - Program reads are byte addressed by Z0
// - Buffer words load in any order
// - Erase command, store within four cycles
// - NO_READ_WHILE_WRITE_SECTION target halts CPU; READ_WHILE_WRITE_SECTION target not
// - Load command stores data at buffer word
// - Buffer cleared after write, re-enable, reset
// - EEPROM write during loading discards buffer
// - Write command, page number in Z
// - Interrupt held while enable bit clear
// - Busy flag set, READ_WHILE_WRITE_SECTION reads blocked
// - Busy flag stays until re-enable written
// - Lock command programs zero data bits
// - Lock programming blocks no flash reads
// - Armed command expires after four cycles
// - Operations last 3.7 to 4.5 ms
// - EEPROM write blocks programming commands
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module fsp_sequencer #(
  parameter int OP_CYCLES = fsp_pkg::OP_CYCLES_MIN
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire fsp_pkg::fsp_axi_req_t i_axi,
  output fsp_pkg::fsp_axi_rsp_t     o_axi,
  input  wire logic                 i_eeprom_write_in_progress,
  input  wire logic                 i_boot_reset_fuse,
  input  wire logic                 i_prog_rd_req,
  input  wire logic [15:0]          i_prog_rd_addr,
  output logic [7:0]                o_prog_rd_data,
  output logic [15:0]               o_reset_vector,
  output logic                      o_cpu_halt,
  output logic                      o_rww_read_blocked,
  output logic                      o_spm_irq,
  output logic [5:0]                o_lock_bits
);
  import fsp_pkg::*;

  typedef enum logic {ST_IDLE, ST_BUSY} fsp_state_t;

  typedef struct packed {
    fsp_state_t            state;
    logic [4:0]            cmd;
    logic                  int_en;
    logic                  busy_flag;
    logic [2:0]            arm_cnt;
    logic [15:0]           z;
    logic [15:0]           dat;
    fsp_op_t               op;
    logic [6:0]            page;
    logic [5:0]            lock_data;
    logic [5:0]            lock;
    logic [19:0]           timer;
    logic [5:0]            widx;
    logic [31:0][15:0]     pbuf;
    logic [31:0]           used;
    logic                  aw_have;
    logic [31:0]           awaddr;
    logic                  w_have;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rd_hi;
    logic                  rd_blk;
  } fsp_st_t;

  fsp_st_t     s_q;
  fsp_st_t     s_d;
  logic        fuse_s;
  logic        fl_we;
  logic [11:0] fl_waddr;
  logic [15:0] fl_wdata;
  logic [15:0] fl_rword;
  logic        wr_go;
  logic        store_go;
  logic        op_done;
  logic        no_read_while_write_section_tgt;
  logic [15:0] flash_mem [FLASH_WORDS];

  fsp_sync2 u_fuse_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_boot_reset_fuse),
    .o_sync  (fuse_s)
  );

  // Bus handshake outputs come straight from state
  assign o_axi.awready = !s_q.aw_have && !s_q.bvalid;
  assign o_axi.wready  = !s_q.w_have && !s_q.bvalid;
  assign o_axi.bvalid  = s_q.bvalid;
  assign o_axi.bresp   = s_q.bresp;
  assign o_axi.arready = !s_q.rvalid;
  assign o_axi.rvalid  = s_q.rvalid;
  assign o_axi.rdata   = s_q.rdata;
  assign o_axi.rresp   = s_q.rresp;

  assign wr_go    = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign store_go = wr_go && s_q.awaddr == OFS_STORE && s_q.arm_cnt != 3'h0
                    && s_q.state == ST_IDLE;
  assign op_done  = s_q.state == ST_BUSY && s_q.timer == 20'(OP_CYCLES - 1);
  assign no_read_while_write_section_tgt = s_q.page >= NO_READ_WHILE_WRITE_SECTION_PAGE;

  // Page update runs one word per cycle at the start of the operation
  assign fl_we    = s_q.state == ST_BUSY && s_q.op != OP_LOCK
                    && s_q.widx < 6'(PAGE_WORDS);
  assign fl_waddr = {s_q.page, s_q.widx[4:0]};
  assign fl_wdata = (s_q.op == OP_ERASE) ? 16'hffff : s_q.pbuf[s_q.widx[4:0]];

  always_comb begin
    s_d = s_q;
    // Write channel capture, either order
    if (i_axi.awvalid && o_axi.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = i_axi.awaddr;
    end
    if (i_axi.wvalid && o_axi.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = i_axi.wdata;
      s_d.wstrb  = i_axi.wstrb;
    end
    if (s_q.bvalid && i_axi.bready) begin
      s_d.bvalid = 1'b0;
    end
    // Arm window countdown
    if (s_q.arm_cnt != 3'h0) begin
      s_d.arm_cnt = s_q.arm_cnt - 3'h1;
      // A store taken in the last armed cycle must keep its command
      if (s_q.arm_cnt == 3'h1 && s_q.state == ST_IDLE
          && !(store_go && !i_eeprom_write_in_progress)) begin
        s_d.cmd = 5'h00;
      end
    end
    // EEPROM write while loading: partial page would be corrupt anyway
    if (i_eeprom_write_in_progress && s_q.used != 32'h0 && s_q.state == ST_IDLE) begin
      s_d.used = 32'h0;
      s_d.pbuf = '1;
    end
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (s_q.awaddr == OFS_CTRL) begin
        if (s_q.wstrb[0]) begin
          s_d.int_en = s_q.wdata[BIT_IEN];
          // Commands refused while busy or while EEPROM writes
          if (s_q.state == ST_IDLE && !i_eeprom_write_in_progress) begin
            if (s_q.wdata[4:0] == CMD_REEN) begin
              s_d.pbuf      = '1;
              s_d.used      = 32'h0;
              s_d.busy_flag = 1'b0;
            end else if (s_q.wdata[BIT_EN]) begin
              s_d.cmd     = s_q.wdata[4:0];
              s_d.arm_cnt = ARM_WINDOW;
            end
          end
        end
      end else if (s_q.awaddr == OFS_Z) begin
        if (s_q.wstrb[0]) begin
          s_d.z[7:0] = s_q.wdata[7:0];
        end
        if (s_q.wstrb[1]) begin
          s_d.z[15:8] = s_q.wdata[15:8];
        end
      end else if (s_q.awaddr == OFS_DATA) begin
        if (s_q.wstrb[0]) begin
          s_d.dat[7:0] = s_q.wdata[7:0];
        end
        if (s_q.wstrb[1]) begin
          s_d.dat[15:8] = s_q.wdata[15:8];
        end
      end else if (s_q.awaddr == OFS_STORE || s_q.awaddr == OFS_INFO) begin
        // Store strobe, or read-only info; fuses have no write path
        s_d.bresp = RESP_OKAY;
      end else begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    // Store-program execution
    if (store_go && !i_eeprom_write_in_progress) begin
      s_d.arm_cnt = 3'h0;
      s_d.timer   = 20'h0;
      s_d.widx    = 6'h0;
      if (s_q.cmd == CMD_LOAD) begin
        s_d.pbuf[s_q.z[Z_WORD_LSB +: 5]] = s_q.dat;
        s_d.used[s_q.z[Z_WORD_LSB +: 5]] = 1'b1;
        s_d.cmd = 5'h00;
      end else if (s_q.cmd == CMD_ERASE || s_q.cmd == CMD_WRITE) begin
        s_d.state     = ST_BUSY;
        s_d.op        = (s_q.cmd == CMD_ERASE) ? OP_ERASE : OP_WRITE;
        s_d.page      = s_q.z[Z_PAGE_LSB +: 7];
        s_d.busy_flag = 1'b1;
      end else if (s_q.cmd == CMD_LOCK) begin
        // Z pointer deliberately not sampled here
        s_d.state     = ST_BUSY;
        s_d.op        = OP_LOCK;
        s_d.lock_data = s_q.dat[5:0];
      end
    end
    if (s_q.state == ST_BUSY) begin
      s_d.timer = s_q.timer + 20'h1;
      if (fl_we) begin
        s_d.widx = s_q.widx + 6'h1;
      end
      if (op_done) begin
        s_d.state = ST_IDLE;
        s_d.cmd   = 5'h00;
        if (s_q.op == OP_LOCK) begin
          s_d.lock = s_q.lock & s_q.lock_data;
        end
        if (s_q.op == OP_WRITE) begin
          s_d.pbuf = '1;
          s_d.used = 32'h0;
        end
      end
    end
    // Register reads
    if (s_q.rvalid && i_axi.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (i_axi.arvalid && o_axi.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0;
      if (i_axi.araddr == OFS_CTRL) begin
        s_d.rdata[7:0] = {s_q.int_en, s_q.busy_flag, 1'b0, s_q.cmd};
      end else if (i_axi.araddr == OFS_Z) begin
        s_d.rdata[15:0] = s_q.z;
      end else if (i_axi.araddr == OFS_DATA) begin
        s_d.rdata[15:0] = s_q.dat;
      end else if (i_axi.araddr == OFS_STORE) begin
        s_d.rdata = 32'h0;
      end else if (i_axi.araddr == OFS_INFO) begin
        s_d.rdata[22:0] = {fuse_s, o_reset_vector, s_q.lock};
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end
    // Program read: byte lane from Z0, READ_WHILE_WRITE_SECTION blocked while busy flag set
    if (i_prog_rd_req) begin
      s_d.rd_hi  = i_prog_rd_addr[0];
      s_d.rd_blk = s_q.busy_flag && i_prog_rd_addr[12:6] < NO_READ_WHILE_WRITE_SECTION_PAGE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q       <= '0;
      s_q.state <= ST_IDLE;
      s_q.op    <= OP_ERASE;
      s_q.lock  <= LOCK_RESET;
      s_q.pbuf  <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // Flash array, no reset: contents are non-volatile
  always_ff @(posedge i_clk) begin
    if (fl_we) begin
      flash_mem[fl_waddr] <= fl_wdata;
    end
    fl_rword <= flash_mem[i_prog_rd_addr[12:1]];
  end

  assign o_prog_rd_data     = s_q.rd_blk ? 8'hff
                              : (s_q.rd_hi ? fl_rword[15:8] : fl_rword[7:0]);
  assign o_reset_vector     = fuse_s ? APP_RESET : BOOT_RESET;
  assign o_cpu_halt         = s_q.state == ST_BUSY && s_q.op != OP_LOCK && no_read_while_write_section_tgt;
  assign o_rww_read_blocked = s_q.busy_flag;
  assign o_spm_irq          = s_q.int_en && !s_q.cmd[BIT_EN];
  assign o_lock_bits        = s_q.lock;

  // Checks
  sequence seq_op_end;
    s_q.state == ST_BUSY && s_q.timer == 20'(OP_CYCLES - 1);
  endsequence
  sequence seq_idle_clear;
    s_q.state == ST_IDLE && !s_q.cmd[BIT_EN];
  endsequence

  AST_RESET_VEC: assert property (@(posedge i_clk) disable iff (i_srst)
    o_reset_vector == (fuse_s ? APP_RESET : BOOT_RESET))
    else $error("reset vector does not follow fuse");
  AST_ARM_EXPIRE: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.arm_cnt == 3'h1 && s_q.state == ST_IDLE && !wr_go) |=> s_q.cmd == 5'h00)
    else $error("armed command did not expire");
  AST_PAGE_HELD: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.state == ST_BUSY && $past(s_q.state) == ST_BUSY) |-> $stable(s_q.page))
    else $error("latched page changed");
  AST_HALT_NO_READ_WHILE_WRITE_SECTION: assert property (@(posedge i_clk) disable iff (i_srst)
    (store_go && !i_eeprom_write_in_progress && (s_q.cmd == CMD_ERASE || s_q.cmd == CMD_WRITE))
      |=> (o_cpu_halt == ($past(s_q.z[Z_PAGE_LSB +: 7]) >= NO_READ_WHILE_WRITE_SECTION_PAGE)))
    else $error("halt does not match target section");
  AST_LOCK_FREE: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.state == ST_BUSY && s_q.op == OP_LOCK) |-> !o_cpu_halt)
    else $error("lock programming halted the core");
  AST_BUSY_FLAG: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.state == ST_BUSY && s_q.op != OP_LOCK) |-> o_rww_read_blocked)
    else $error("busy flag clear during page operation");
  AST_FLAG_STAYS: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_rww_read_blocked && !wr_go) |=> o_rww_read_blocked)
    else $error("busy flag cleared without re-enable");
  AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.int_en && !s_q.cmd[BIT_EN]) [*2] |-> o_spm_irq)
    else $error("interrupt not held");
  AST_DONE_CLEAR: assert property (@(posedge i_clk) disable iff (i_srst)
    seq_op_end |=> seq_idle_clear)
    else $error("enable not cleared at completion");
  AST_BUF_CLEAR: assert property (@(posedge i_clk) disable iff (i_srst)
    (seq_op_end ##0 s_q.op == OP_WRITE) |=> s_q.used == 32'h0)
    else $error("buffer not cleared after write");
  AST_EE_BLOCK: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_eeprom_write_in_progress && s_q.state == ST_IDLE && s_q.arm_cnt == 3'h0)
      |=> s_q.state == ST_IDLE)
    else $error("operation started during EEPROM write");
  AST_LOAD_DONE: assert property (@(posedge i_clk) disable iff (i_srst)
    (store_go && !i_eeprom_write_in_progress && s_q.cmd == CMD_LOAD)
      |=> (!s_q.cmd[BIT_EN] && s_q.used != 32'h0))
    else $error("buffer load did not complete");
  AST_EE_DISCARD: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_eeprom_write_in_progress && s_q.state == ST_IDLE && s_q.used != 32'h0)
      |=> s_q.used == 32'h0)
    else $error("loaded words kept across EEPROM write");
  AST_REEN_CLEAR: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_go && s_q.awaddr == OFS_CTRL && s_q.wstrb[0] && s_q.wdata[4:0] == CMD_REEN
      && s_q.state == ST_IDLE && !i_eeprom_write_in_progress)
      |=> (!o_rww_read_blocked && s_q.used == 32'h0))
    else $error("re-enable left section busy or buffer loaded");
  AST_LOCK_NO_BUSY: assert property (@(posedge i_clk) disable iff (i_srst)
    (store_go && !i_eeprom_write_in_progress && s_q.cmd == CMD_LOCK)
      |=> $stable(s_q.busy_flag))
    else $error("lock programming changed the busy flag");
  AST_RD_BLOCK: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_prog_rd_req && s_q.busy_flag && i_prog_rd_addr[12:6] < NO_READ_WHILE_WRITE_SECTION_PAGE)
      |=> o_prog_rd_data == 8'hff)
    else $error("busy section read not blocked");
endmodule

// file: fsp_sync2.sv
// Two-flop level synchroniser.
// Assumes the input is a slow static level from a pin.
`timescale 1ns/10ps
module fsp_sync2 (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic [1:0] stage_q;
  // Reset to one: an unprogrammed fuse reads high
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage_q <= 2'b11;
    end else begin
      stage_q <= {stage_q[0], i_async};
    end
  end
  assign o_sync = stage_q[1];
endmodule

// file: tb.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes a shortened operation length; all traffic goes through the core model.
`timescale 1ns/10ps
module tb;
  import fsp_pkg::*;
  localparam int OPC = 64;
  logic         i_clk, i_srst, ee_busy, fuse;
  fsp_axi_req_t axi_req;
  fsp_axi_rsp_t axi_rsp;
  logic         rd_req, halt, blocked, irq;
  logic [15:0]  rd_addr, vec;
  logic [7:0]   rd_data;
  logic [5:0]   lock;
  logic [31:0]  d;
  logic [1:0]   r;
  int           miscompares, samples_checked, halt_cnt;
  fsp_sequencer #(.OP_CYCLES(OPC)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_axi(axi_req),
    .o_axi(axi_rsp), .i_eeprom_write_in_progress(ee_busy), .i_boot_reset_fuse(fuse),
    .i_prog_rd_req(rd_req), .i_prog_rd_addr(rd_addr), .o_prog_rd_data(rd_data),
    .o_reset_vector(vec), .o_cpu_halt(halt), .o_rww_read_blocked(blocked),
    .o_spm_irq(irq), .o_lock_bits(lock));
  fsp_core_model core (.i_axi(axi_rsp), .i_clk(i_clk), .i_prog_rd_data(rd_data),
    .o_axi(axi_req), .o_prog_rd_req(rd_req), .o_prog_rd_addr(rd_addr));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (halt === 1'b1) halt_cnt++;
  end
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic lost(input logic ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected bus wait: expected answer, seen none");
      test_done();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic ok;
    core.wr(a, v, ok);
    lost(ok);
  endtask
  task automatic rd(input logic [31:0] a);
    logic ok;
    core.rd(a, d, r, ok);
    lost(ok);
  endtask
  task automatic fchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] b;
    core.fetch(a, b);
    chk("program byte", exp, b);
  endtask
  function automatic logic [31:0] ctl(input logic [4:0] cmd);
    return {24'h0, 1'b1, 2'b00, cmd};
  endfunction
  task automatic start(input logic [4:0] cmd, input logic [15:0] z, input logic [15:0] v);
    wr(OFS_Z, {16'h0, z});
    wr(OFS_DATA, {16'h0, v});
    wr(OFS_CTRL, ctl(cmd));
    wr(OFS_STORE, 32'h0);
  endtask
  task automatic wait_done;
    for (int n = 0; n < 200; n++) begin
      rd(OFS_CTRL);
      if (d[BIT_EN] === 1'b0) return;
    end
    lost(1'b0);
  endtask
  task automatic t_reset;
    chk("lock bits", 6'h3f, lock);
    chk("halt", 1'b0, halt);
    chk("irq", 1'b0, irq);
    chk("busy flag", 1'b0, blocked);
    rd(OFS_INFO);
    chk("info", 32'h0040_003f, d);
    rd(32'h0000_0020);
    chk("unmapped resp", RESP_SLVERR, r);
    wr(OFS_CTRL, 32'h0000_0080);
    chk("irq idle", 1'b1, irq);
    $display("test reset done");
  endtask
  task automatic t_page;
    start(CMD_LOAD, 16'h008a, 16'ha5c3);
    wait_done();
    start(CMD_LOAD, 16'h0082, 16'h1234);
    wait_done();
    start(CMD_ERASE, 16'h0080, 16'hffff);
    rd(OFS_CTRL);
    chk("busy bit", 1'b1, d[BIT_BUSY]);
    chk("halt rww", 1'b0, halt);
    chk("irq busy", 1'b0, irq);
    fchk(16'h0000, 8'hff);
    wait_done();
    chk("irq done", 1'b1, irq);
    start(CMD_WRITE, 16'h0080, 16'h5555);
    wait_done();
    chk("busy after write", 1'b1, blocked);
    fchk(16'h008a, 8'hff);
    wr(OFS_CTRL, ctl(CMD_REEN));
    @(posedge i_clk);
    chk("busy cleared", 1'b0, blocked);
    fchk(16'h008a, 8'hc3);
    fchk(16'h008b, 8'ha5);
    fchk(16'h0083, 8'h12);
    fchk(16'h0084, 8'hff);
    $display("test page done");
  endtask
  task automatic t_discard;
    start(CMD_LOAD, 16'h00c0, 16'h0000);
    wait_done();
    ee_busy <= 1'b1;
    @(posedge i_clk);
    wr(OFS_CTRL, ctl(CMD_ERASE));
    rd(OFS_CTRL);
    chk("arm blocked", 1'b0, d[BIT_EN]);
    ee_busy <= 1'b0;
    start(CMD_ERASE, 16'h00c0, 16'h0000);
    wait_done();
    start(CMD_WRITE, 16'h00c0, 16'h0000);
    wait_done();
    wr(OFS_CTRL, ctl(CMD_REEN));
    fchk(16'h00c0, 8'hff);
    fchk(16'h00c2, 8'hff);
    $display("test discard done");
  endtask
  task automatic t_no_read_while_write_section;
    halt_cnt = 0;
    start(CMD_ERASE, 16'h1800, 16'h0000);
    chk("halt no_read_while_write_section", 1'b1, halt);
    wr(OFS_Z, 32'h0000_0080);
    chk("halt kept", 1'b1, halt);
    wait_done();
    chk("halt length", 1'b1, halt_cnt >= OPC && halt_cnt <= OPC + 2);
    wr(OFS_CTRL, ctl(CMD_REEN));
    wr(OFS_CTRL, ctl(CMD_LOAD));
    repeat (6) @(posedge i_clk);
    rd(OFS_CTRL);
    chk("arm expired", 1'b0, d[BIT_EN]);
    $display("test no_read_while_write_section done");
  endtask
  task automatic t_sysreset;
    start(CMD_LOAD, 16'h0100, 16'h0000);
    wait_done();
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("irq after reset", 1'b0, irq);
    start(CMD_ERASE, 16'h0100, 16'h0000);
    wait_done();
    start(CMD_WRITE, 16'h0100, 16'h0000);
    wait_done();
    wr(OFS_CTRL, ctl(CMD_REEN));
    fchk(16'h0100, 8'hff);
    $display("test system reset done");
  endtask
  task automatic t_lock;
    start(CMD_LOCK, 16'hffff, 16'h00f2);
    chk("lock no block", 1'b0, blocked);
    chk("lock no halt", 1'b0, halt);
    wait_done();
    chk("lock bits", 6'h32, lock);
    wr(OFS_INFO, 32'h0);
    chk("vector kept", APP_RESET, vec);
    fuse <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("boot vector", BOOT_RESET, vec);
    $display("test lock done");
  endtask
  initial begin
    i_srst = 1'b1;
    ee_busy = 1'b0;
    fuse = 1'b1;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_clk);
    t_reset();
    t_page();
    t_discard();
    t_no_read_while_write_section();
    t_sysreset();
    t_lock();
    test_done();
  end
endmodule
